// file: logic/bert_defs.svh
// constants for the pseudo-random bit error checker
`ifndef BERT_DEFS_SVH
`define BERT_DEFS_SVH

`define CNT_W 32
`define POLY_W 3
`define SR_W 23
`define FILL_W 5
`define CHK_W 6

`define POLY_PN9 3'h0
`define POLY_PN11 3'h1
`define POLY_PN15 3'h2
`define POLY_PN16 3'h3
`define POLY_PN20 3'h4
`define POLY_PN21 3'h5
`define POLY_PN23 3'h6

`define PN9_N 9
`define PN9_A1 4
`define PN11_N 11
`define PN11_A1 2
`define PN15_N 15
`define PN15_A1 1
`define PN16_N 16
`define PN16_A1 5
`define PN16_A2 3
`define PN16_A3 2
`define PN20_N 20
`define PN20_A1 3
`define PN21_N 21
`define PN21_A1 2
`define PN23_N 23
`define PN23_A1 5

`define ST_IDLE 4'h1
`define ST_FILL 4'h2
`define ST_RUN 4'h4
`define ST_DONE 4'h8

// bits checked right after filling to judge whether lock was good
`define LOCK_CHECK_BITS 6'h20
// more errors than this within the check window means a bad fill
`define LOCK_ERR_LIMIT 6'h0C

`define ONE_CNT 32'h0000_0001
`define ONE_FILL 5'h01
`define ONE_CHK 6'h01

`endif

// file: logic/bert_pkg.sv
// types and polynomial helpers for the bit error checker
package bert_pkg;
`include "bert_defs.svh"

  typedef logic [`POLY_W-1:0] poly_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef logic [`SR_W-1:0] sr_t;

  typedef enum logic [3:0]
  {
    ST_IDLE = `ST_IDLE,
    ST_FILL = `ST_FILL,
    ST_RUN = `ST_RUN,
    ST_DONE = `ST_DONE
  } link_st_t;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  typedef struct packed
  {
    logic clk_inv;
    logic data_inv;
    poly_t poly;
    logic gate_en;
    logic gate_high;
    logic ext_mode;
    cnt_t limit_total;
    cnt_t limit_err;
    logic start_tgl;
    logic done_seen;
    logic busy;
    logic done;
    cnt_t total;
    cnt_t errors;
    logic by_total;
    logic by_err;
  } sys_state_t;

  typedef struct packed
  {
    link_st_t st;
    sr_t sr;
    logic [`FILL_W-1:0] fill_cnt;
    logic [`CHK_W-1:0] chk_cnt;
    logic [`CHK_W-1:0] chk_err;
    cnt_t total;
    cnt_t errors;
    logic by_total;
    logic by_err;
    logic done_tgl;
    logic start_seen;
    logic data_inv;
    poly_t poly;
    logic gate_en;
    logic gate_high;
    logic ext_mode;
    cnt_t limit_total;
    cnt_t limit_err;
  } link_state_t;

  function automatic logic [`FILL_W-1:0] poly_degree(input poly_t p);
    case (p)
      `POLY_PN9: poly_degree = `FILL_W'(`PN9_N);
      `POLY_PN11: poly_degree = `FILL_W'(`PN11_N);
      `POLY_PN15: poly_degree = `FILL_W'(`PN15_N);
      `POLY_PN16: poly_degree = `FILL_W'(`PN16_N);
      `POLY_PN20: poly_degree = `FILL_W'(`PN20_N);
      `POLY_PN21: poly_degree = `FILL_W'(`PN21_N);
      `POLY_PN23: poly_degree = `FILL_W'(`PN23_N);
      default: poly_degree = `FILL_W'(`PN9_N);
    endcase
  endfunction : poly_degree

  // sequences sent inverted are turned back before they enter the register
  function automatic logic poly_inverted(input poly_t p);
    poly_inverted = (p == `POLY_PN15) || (p == `POLY_PN23);
  endfunction : poly_inverted

  // sr[0] holds the newest bit; result is the bit the sequence must carry next
  function automatic logic predict_bit(input sr_t sr, input poly_t p);
    case (p)
      `POLY_PN9: predict_bit = sr[`PN9_N-1] ^ sr[`PN9_A1-1];
      `POLY_PN11: predict_bit = sr[`PN11_N-1] ^ sr[`PN11_A1-1];
      `POLY_PN15: predict_bit = sr[`PN15_N-1] ^ sr[`PN15_A1-1];
      `POLY_PN16: predict_bit = sr[`PN16_N-1] ^ sr[`PN16_A1-1] ^ sr[`PN16_A2-1]
                                ^ sr[`PN16_A3-1];
      `POLY_PN20: predict_bit = sr[`PN20_N-1] ^ sr[`PN20_A1-1];
      `POLY_PN21: predict_bit = sr[`PN21_N-1] ^ sr[`PN21_A1-1];
      `POLY_PN23: predict_bit = sr[`PN23_N-1] ^ sr[`PN23_A1-1];
      default: predict_bit = sr[`PN9_N-1] ^ sr[`PN9_A1-1];
    endcase
  endfunction : predict_bit

endpackage : bert_pkg

// file: logic/level_sync.sv
// three-stage level synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module level_sync
  import bert_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_async,
  output logic o_level
);

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.level = st_r.s3;
    end
  end

  // no reset: this also carries the reset itself into the link domain
  always_ff @(posedge i_clk)
  begin
    st_r <= st_nxt;
  end

  assign o_level = st_r.level;

endmodule : level_sync
`default_nettype wire

// file: logic/bert_checker.sv
// pseudo-random sequence bit error checker running on the received bit clock
// What this block does
// - the checker locks onto the expected sequence and then counts every disagreeing bit.
// - clock polarity and data polarity are each selectable on their own.
// - software picks the generator polynomial and the length of a measurement.
// - one counter holds all evaluated bits and another the wrong bits.
// - the reference comes from a shift register tapped as the chosen polynomial says.
// - the register is first filled with received bits, then runs on its own feedback.
// - in feedback each received bit is compared with the prediction; a mismatch is one error.
// - analysis may begin anywhere in the sequence whatever the transport delay.
// - the checker works on data from any external source.
// - with gating on and high polarity, bits count only while data valid is one.
// - in external restart mode a high restart holds the measurement in reset, low runs it.
// - both counters are 32 bits wide.
// - a measurement ends at the error limit or the total limit and reports which.
`timescale 1ns/1ps
`default_nettype none
`include "bert_defs.svh"
module bert_checker
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_clk_inv,
  input wire logic i_data_inv,
  input wire bert_pkg::poly_t i_poly,
  input wire logic i_gate_en,
  input wire logic i_gate_high,
  input wire logic i_ext_restart_mode,
  input wire bert_pkg::cnt_t i_limit_total,
  input wire bert_pkg::cnt_t i_limit_err,
  input wire logic i_bit_clk,
  input wire logic i_bit_data,
  input wire logic i_data_valid_gate,
  input wire logic i_measurement_restart_input,
  output logic o_busy,
  output logic o_done,
  output bert_pkg::cnt_t o_total,
  output bert_pkg::cnt_t o_errors,
  output logic o_end_by_total,
  output logic o_end_by_errors
);
  import bert_pkg::*;

  sys_state_t sys_r;
  sys_state_t sys_nxt;
  link_state_t link_r;
  link_state_t link_nxt;

  logic link_clk;
  logic link_rst_ok;
  logic start_lvl;
  logic done_lvl;

  // polarity only changes with a start, when the link side is idle or about to restart
  assign link_clk = i_bit_clk ^ sys_r.clk_inv;

  level_sync u_rst_sync
  (
    .i_clk(link_clk),
    .i_async(i_rst_b),
    .o_level(link_rst_ok)
  );

  level_sync u_start_sync
  (
    .i_clk(link_clk),
    .i_async(sys_r.start_tgl),
    .o_level(start_lvl)
  );

  level_sync u_done_sync
  (
    .i_clk(i_clk),
    .i_async(link_r.done_tgl),
    .o_level(done_lvl)
  );

  // system side: settings, start handshake and result capture
  always_comb
  begin
    sys_nxt = sys_r;
    sys_nxt.done = 1'b0;
    if (done_lvl != sys_r.done_seen)
    begin
      // link results are frozen until the next start, so they are safe to copy here
      sys_nxt.done_seen = done_lvl;
      sys_nxt.total = link_r.total;
      sys_nxt.errors = link_r.errors;
      sys_nxt.by_total = link_r.by_total;
      sys_nxt.by_err = link_r.by_err;
      sys_nxt.busy = 1'b0;
      sys_nxt.done = 1'b1;
    end
    if (i_start)
    begin
      sys_nxt.clk_inv = i_clk_inv;
      sys_nxt.data_inv = i_data_inv;
      sys_nxt.poly = i_poly;
      sys_nxt.gate_en = i_gate_en;
      sys_nxt.gate_high = i_gate_high;
      sys_nxt.ext_mode = i_ext_restart_mode;
      sys_nxt.limit_total = i_limit_total;
      sys_nxt.limit_err = i_limit_err;
      sys_nxt.start_tgl = ~sys_r.start_tgl;
      sys_nxt.busy = 1'b1;
    end
    if (!i_rst_b)
    begin
      sys_nxt = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    sys_r <= sys_nxt;
  end

  // link side: sampling, fill, feedback compare and counting
  logic bit_in;
  logic counted;
  logic pred;
  logic bit_err;
  cnt_t total_inc;
  cnt_t err_inc;
  logic hit_total;
  logic hit_err;

  always_comb
  begin
    link_nxt = link_r;
    bit_in = i_bit_data ^ link_r.data_inv ^ poly_inverted(link_r.poly);
    counted = !link_r.gate_en
              || (i_data_valid_gate == link_r.gate_high);
    pred = predict_bit(link_r.sr, link_r.poly);
    bit_err = bit_in != pred;
    total_inc = link_r.total + `ONE_CNT;
    err_inc = link_r.errors + (bit_err ? `ONE_CNT : '0);
    // a zero limit switches that criterion off
    hit_total = (link_r.limit_total != '0) && (total_inc >= link_r.limit_total);
    hit_err = (link_r.limit_err != '0) && (err_inc >= link_r.limit_err);
    if (start_lvl != link_r.start_seen)
    begin
      // configuration is copied only here; the system side holds it stable meanwhile
      link_nxt.start_seen = start_lvl;
      link_nxt.data_inv = sys_r.data_inv;
      link_nxt.poly = sys_r.poly;
      link_nxt.gate_en = sys_r.gate_en;
      link_nxt.gate_high = sys_r.gate_high;
      link_nxt.ext_mode = sys_r.ext_mode;
      link_nxt.limit_total = sys_r.limit_total;
      link_nxt.limit_err = sys_r.limit_err;
      link_nxt.total = '0;
      link_nxt.errors = '0;
      link_nxt.by_total = 1'b0;
      link_nxt.by_err = 1'b0;
      link_nxt.fill_cnt = '0;
      link_nxt.st = ST_FILL;
    end
    else if ((link_r.st == ST_FILL || link_r.st == ST_RUN)
             && link_r.ext_mode && i_measurement_restart_input)
    begin
      // held here for as long as restart stays high
      link_nxt.total = '0;
      link_nxt.errors = '0;
      link_nxt.fill_cnt = '0;
      link_nxt.st = ST_FILL;
    end
    else if (counted)
    begin
      case (link_r.st)
        ST_FILL:
        begin
          // any position of the stream will do: the register just learns it
          link_nxt.sr = {link_r.sr[`SR_W-2:0], bit_in};
          link_nxt.fill_cnt = link_r.fill_cnt + `ONE_FILL;
          if (link_nxt.fill_cnt >= poly_degree(link_r.poly))
          begin
            link_nxt.st = ST_RUN;
            link_nxt.chk_cnt = '0;
            link_nxt.chk_err = '0;
          end
        end
        ST_RUN:
        begin
          link_nxt.sr = {link_r.sr[`SR_W-2:0], pred};
          link_nxt.total = total_inc;
          link_nxt.errors = err_inc;
          if (link_r.chk_cnt != `LOCK_CHECK_BITS)
          begin
            link_nxt.chk_cnt = link_r.chk_cnt + `ONE_CHK;
            link_nxt.chk_err = link_r.chk_err + (bit_err ? `ONE_CHK : '0);
          end
          if (link_r.chk_cnt != `LOCK_CHECK_BITS && link_nxt.chk_err > `LOCK_ERR_LIMIT)
          begin
            // a wrong bit during fill poisons every prediction; refill silently
            link_nxt.total = '0;
            link_nxt.errors = '0;
            link_nxt.fill_cnt = '0;
            link_nxt.st = ST_FILL;
          end
          else if (hit_total || hit_err)
          begin
            link_nxt.by_total = hit_total;
            link_nxt.by_err = hit_err;
            link_nxt.done_tgl = ~link_r.done_tgl;
            link_nxt.st = ST_DONE;
          end
        end
        ST_IDLE, ST_DONE:
        begin
          link_nxt.st = link_r.st;
        end
        default:
        begin
          link_nxt.st = ST_IDLE;
        end
      endcase
    end
    if (!link_rst_ok)
    begin
      link_nxt = '0;
      link_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge link_clk)
  begin
    link_r <= link_nxt;
  end

  assign o_busy = sys_r.busy;
  assign o_done = sys_r.done;
  assign o_total = sys_r.total;
  assign o_errors = sys_r.errors;
  assign o_end_by_total = sys_r.by_total;
  assign o_end_by_errors = sys_r.by_err;

endmodule : bert_checker
`default_nettype wire

// file: dv/bert_checker_assertions.sv
// concurrent checks on the ports of the bit error checker
`timescale 1ns/1ps
`default_nettype none
module bert_checker_assertions
  import bert_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire cnt_t i_limit_total,
  input wire cnt_t i_limit_err,
  input wire logic o_busy,
  input wire logic o_done,
  input wire cnt_t o_total,
  input wire cnt_t o_errors,
  input wire logic o_end_by_total,
  input wire logic o_end_by_errors
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_start_busy: assert property (i_start |=> o_busy)
    else $error("busy not raised after start");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_idle: assert property (o_done |-> !o_busy && $past(o_busy))
    else $error("done without a preceding busy phase");
  a_busy_fall: assert property ($fell(o_busy) |-> o_done)
    else $error("busy dropped without done");
  a_total_end: assert property (o_done && o_end_by_total |-> o_total == i_limit_total)
    else $error("total differs from its limit");
  a_err_end: assert property (o_done && o_end_by_errors |-> o_errors == i_limit_err)
    else $error("error count differs from its limit");
  a_end_reason: assert property (o_done |-> o_end_by_total || o_end_by_errors)
    else $error("done without an ending reason");
  a_err_bound: assert property (o_done |-> o_errors <= o_total)
    else $error("more errors than bits");
  a_result_hold: assert property (!o_done |-> $stable(o_total) && $stable(o_errors))
    else $error("results moved without done");

  cover property (o_done && o_end_by_total);
  cover property (o_done && o_end_by_errors);
  cover property (i_start ##1 o_busy);
endmodule : bert_checker_assertions

bind bert_checker bert_checker_assertions chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_start(i_start), .i_limit_total(i_limit_total), .i_limit_err(i_limit_err),
  .o_busy(o_busy), .o_done(o_done), .o_total(o_total), .o_errors(o_errors),
  .o_end_by_total(o_end_by_total), .o_end_by_errors(o_end_by_errors));
`default_nettype wire

// file: dv/prbs_far_end.sv
// far-end source: pseudo-random bits on a data line with their own bit clock
`timescale 1ns/1ps
`default_nettype none
`include "bert_defs.svh"
module prbs_far_end
  import bert_pkg::*;
(
  input wire logic i_en,
  input wire logic i_clk_inv,
  input wire logic i_data_inv,
  input wire poly_t i_poly,
  input wire logic i_gap,
  input wire logic i_valid_high,
  input wire logic i_err_on,
  input wire logic i_hold,
  output logic o_bit_clk,
  output logic o_data,
  output logic o_valid,
  output logic o_restart
);
  sr_t sr_r = '1;
  logic [3:0] cnt_r = 4'h0;
  logic nb;

  function automatic logic next_bit(input sr_t s, input poly_t p);
    case (p)
      `POLY_PN11: next_bit = s[`PN11_N-1] ^ s[`PN11_A1-1];
      `POLY_PN15: next_bit = s[`PN15_N-1] ^ s[`PN15_A1-1];
      `POLY_PN16: next_bit = s[`PN16_N-1] ^ s[`PN16_A1-1] ^ s[`PN16_A2-1] ^ s[`PN16_A3-1];
      `POLY_PN20: next_bit = s[`PN20_N-1] ^ s[`PN20_A1-1];
      `POLY_PN21: next_bit = s[`PN21_N-1] ^ s[`PN21_A1-1];
      `POLY_PN23: next_bit = s[`PN23_N-1] ^ s[`PN23_A1-1];
      default: next_bit = s[`PN9_N-1] ^ s[`PN9_A1-1];
    endcase
  endfunction : next_bit

  // own clock, unrelated in phase; it parks low between frames
  initial
  begin
    o_bit_clk = 1'b0;
    o_data = 1'b0;
    o_valid = 1'b0;
    o_restart = 1'b0;
    #17;
    forever
    begin
      #40;
      if (i_en || o_bit_clk)
        o_bit_clk = ~o_bit_clk;
    end
  end

  // a stopped link carries no stable data
  always #40 if (!i_en) o_data = ~o_data;

  // change on the edge the checker does not sample, one register step per good bit
  always @(o_bit_clk)
  begin
    if (o_bit_clk == i_clk_inv)
    begin
      cnt_r = cnt_r + 4'h1;
      o_restart = i_hold;
      if (i_gap && cnt_r[1:0] == 2'h3)
      begin
        o_valid = ~i_valid_high;
        o_data = ~o_data;
      end
      else
      begin
        nb = next_bit(sr_r, i_poly);
        sr_r = {sr_r[`SR_W-2:0], nb};
        o_valid = i_valid_high;
        o_data = nb ^ (i_poly == `POLY_PN15 || i_poly == `POLY_PN23) ^ i_data_inv
          ^ (i_err_on && cnt_r == 4'hF);
      end
    end
  end
endmodule : prbs_far_end
`default_nettype wire

// file: dv/test_prbs_bit_error_checker.sv
// self-checking bench for the bit error checker
`timescale 1ns/1ps
`default_nettype none
`include "bert_defs.svh"
module test_prbs_bit_error_checker;
  import bert_pkg::*;
  logic i_clk, i_rst_b, i_start, i_clk_inv, i_data_inv, i_gate_en, i_gate_high;
  logic i_ext_restart_mode, bit_clk, bit_data, valid, restart;
  logic o_busy, o_done, o_end_by_total, o_end_by_errors, en, gap, err_on, hold, got;
  poly_t i_poly;
  cnt_t i_limit_total, i_limit_err, o_total, o_errors;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  bert_checker dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_clk_inv(i_clk_inv), .i_data_inv(i_data_inv), .i_poly(i_poly), .i_gate_en(i_gate_en),
    .i_gate_high(i_gate_high), .i_ext_restart_mode(i_ext_restart_mode),
    .i_limit_total(i_limit_total), .i_limit_err(i_limit_err), .i_bit_clk(bit_clk),
    .i_bit_data(bit_data), .i_data_valid_gate(valid), .i_measurement_restart_input(restart),
    .o_busy(o_busy), .o_done(o_done), .o_total(o_total), .o_errors(o_errors),
    .o_end_by_total(o_end_by_total), .o_end_by_errors(o_end_by_errors));

  prbs_far_end far (.i_en(en), .i_clk_inv(i_clk_inv), .i_data_inv(i_data_inv),
    .i_poly(i_poly), .i_gap(gap), .i_valid_high(i_gate_high), .i_err_on(err_on),
    .i_hold(hold), .o_bit_clk(bit_clk), .o_data(bit_data), .o_valid(valid),
    .o_restart(restart));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      summarize();
    end
  end

  task automatic chk(input string name, input cnt_t exp, input cnt_t seen);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_done(input int n, output logic seen);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      if (o_done === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask : wait_done

  // m = clk_inv, data_inv, gate_en, gate_high, ext_restart_mode
  task automatic launch(input poly_t p, input logic [4:0] m, input cnt_t lt, input cnt_t le);
    @(posedge i_clk);
    en <= 1'b1;
    i_poly <= p;
    {i_clk_inv, i_data_inv, i_gate_en, i_gate_high, i_ext_restart_mode} <= m;
    i_limit_total <= lt;
    i_limit_err <= le;
    repeat (6) @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
  endtask : launch

  // a total of all ones means the total is not predictable and is not compared
  task automatic finish_chk(input cnt_t et, input cnt_t ee, input logic bt, input logic be);
    wait_done(3000, got);
    chk("done", 32'h0000_0001, {31'h0000_0000, got});
    if (et !== 32'hFFFF_FFFF)
      chk("total", et, o_total);
    chk("errors", ee, o_errors);
    chk("end_by_total", {31'h0000_0000, bt}, {31'h0000_0000, o_end_by_total});
    chk("end_by_errors", {31'h0000_0000, be}, {31'h0000_0000, o_end_by_errors});
    @(posedge i_clk);
    en <= 1'b0;
    err_on <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : finish_chk

  initial
  begin
    {i_rst_b, i_start, i_clk_inv, i_data_inv, i_gate_en, i_gate_high} = 6'h00;
    {i_ext_restart_mode, gap, err_on, hold} = 4'h0;
    en = 1'b1;
    i_poly = `POLY_PN9;
    i_limit_total = 32'h0000_0000;
    i_limit_err = 32'h0000_0000;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("busy", 32'h0000_0000, {31'h0000_0000, o_busy});
    chk("total", 32'h0000_0000, o_total);
    for (int p = 0; p < 7; p++)
    begin
      launch(poly_t'(p), {p[0], p[1], 3'h0}, 32'h0000_00C8, 32'h0000_0000);
      finish_chk(32'h0000_00C8, 32'h0000_0000, 1'b1, 1'b0);
    end
    launch(`POLY_PN9, 5'h00, 32'h0001_0000, 32'h0000_0003);
    repeat (60) @(posedge i_clk);
    err_on <= 1'b1;
    finish_chk(32'hFFFF_FFFF, 32'h0000_0003, 1'b0, 1'b1);
    gap <= 1'b1;
    for (int g = 0; g < 2; g++)
    begin
      launch(`POLY_PN11, {3'h1, g[0], 1'b0}, 32'h0000_0064, 32'h0000_0001);
      finish_chk(32'h0000_0064, 32'h0000_0000, 1'b1, 1'b0);
    end
    gap <= 1'b0;
    hold <= 1'b1;
    launch(`POLY_PN20, 5'h01, 32'h0000_0096, 32'h0000_0000);
    wait_done(300, got);
    chk("held_done", 32'h0000_0000, {31'h0000_0000, got});
    chk("held_busy", 32'h0000_0001, {31'h0000_0000, o_busy});
    @(posedge i_clk);
    hold <= 1'b0;
    finish_chk(32'h0000_0096, 32'h0000_0000, 1'b1, 1'b0);
    summarize();
  end
endmodule : test_prbs_bit_error_checker
`default_nettype wire
